/* hsl_cfg.svh */
// Register map, field positions, reset values and timing constants
`ifndef HSL_CFG_SVH
`define HSL_CFG_SVH

`define HSL_IDX_REF       6'h0e
`define HSL_IDX_HOLD      6'h0f
`define HSL_IDX_XTAL      6'h10
`define HSL_IDX_RDBK      6'h17
`define HSL_IDX_FILT      6'h18
`define HSL_IDX_LOCKCTL   6'h0d
`define HSL_IDX_STAT      6'h1f

`define HSL_MASK_REF      32'hd77fcfe0
`define HSL_MASK_HOLD     32'hffdfffe0
`define HSL_MASK_XTAL     32'hc0000000
`define HSL_MASK_FILT     32'hff700000
`define HSL_MASK_LOCKCTL  32'h00008000
`define HSL_RESET_WORD    32'h00000000

`define HSL_LOS_SEL       31:30
`define HSL_LOS_EN        28
`define HSL_PIN_TYPE      26:24
`define HSL_BUF_TYPE      22:20
`define HSL_HIGH_TRIP     19:14
`define HSL_LOW_TRIP      11:6
`define HSL_RAIL_EN       5
`define HSL_MAN_CODE      31:22
`define HSL_MAN_MODE      20
`define HSL_EXIT_CNT      19:6
`define HSL_FORCE         5
`define HSL_CRYSTAL_AMPLITUDE_SEL      31:30
`define HSL_CAP_C4        31:28
`define HSL_CAP_C3        27:24
`define HSL_RES_R4        22:20
`define HSL_LOCK_DIS      15
`define HSL_RDBK_CODE     23:14

`define HSL_PIN_OUT_PP    3'h3
`define HSL_PIN_OUT_INV   3'h4
`define HSL_PIN_OUT_OS    3'h5
`define HSL_PIN_OUT_OD    3'h6
`define HSL_PIN_IN_PU     3'h1
`define HSL_PIN_IN_PD     3'h2

`define HSL_CLK_PERIOD_PS 10000
`define HSL_LOS_T0_PS     1200000
`define HSL_LOS_T1_PS     206000
`define HSL_LOS_T2_PS     52900
`define HSL_LOS_T3_PS     23700
`define HSL_LOS_C0        (`HSL_LOS_T0_PS / `HSL_CLK_PERIOD_PS)
`define HSL_LOS_C1        (`HSL_LOS_T1_PS / `HSL_CLK_PERIOD_PS)
`define HSL_LOS_C2        (`HSL_LOS_T2_PS / `HSL_CLK_PERIOD_PS)
`define HSL_LOS_C3        (`HSL_LOS_T3_PS / `HSL_CLK_PERIOD_PS)

`define HSL_DAC_FULL      17'h003ff
`define HSL_TRIP_TOP      17'h0003f

`define HSL_RESP_OKAY     2'h0
`define HSL_RESP_SLVERR   2'h2

`endif

/* hsl_chk_sva.sv */
// Port assertions for the holdover control block
`timescale 1ns/1ps
module hsl_chk (
  input wire logic       aclk,                 // System clock
  input wire logic       aresetn,              // Sync reset
  input wire logic [2:0] ref_clk_in,           // Reference inputs
  input wire logic       first_loop_lock_flag, // Loop lock
  input wire logic       pd_clk_tick,          // Detector tick
  input wire logic       status_pin_oe,        // Pin enable
  input wire logic       status_pin_pull_up,   // Pull-up
  input wire logic       status_pin_pull_down, // Pull-down
  input wire logic [2:0] signal_loss,          // Loss flags
  input wire logic [9:0] tune_dac_code,        // DAC code
  input wire logic       tune_high_flag,       // High trip
  input wire logic       tune_low_flag,        // Low trip
  input wire logic       holdover_active,      // Holdover
  input wire logic       clock_switch_event    // Switch pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  AST_LOS_CLEAR: assert property (signal_loss[0] && (ref_clk_in[0] != $past(ref_clk_in[0])) |=> !signal_loss[0])
    else $error("loss flag kept after activity");
  AST_SWITCH_PULSE: assert property (clock_switch_event |=> !clock_switch_event)
    else $error("switch pulse too long");
  AST_EVENT_HOLD: assert property (clock_switch_event |-> holdover_active)
    else $error("event outside holdover");
  AST_EXIT_LOCKED: assert property ($fell(holdover_active) |-> $past(first_loop_lock_flag) && $past(first_loop_lock_flag, 2))
    else $error("exit without lock");
  AST_EXIT_TICK: assert property ($fell(holdover_active) |-> $past(pd_clk_tick))
    else $error("exit without tick");
  AST_PIN_MODE: assert property ($countones({status_pin_oe, status_pin_pull_up, status_pin_pull_down}) <= 1)
    else $error("pin drive and pulls overlap");
  AST_LOW_AT_ZERO: assert property ((tune_dac_code == 10'h000) [*4] |-> tune_low_flag)
    else $error("no low flag at zero");
  AST_HIGH_AT_TOP: assert property ((tune_dac_code == 10'h3ff) [*4] |-> tune_high_flag)
    else $error("no high flag at top");
  cover property (clock_switch_event);
  cover property ($fell(holdover_active));
  cover property ($rose(signal_loss[1]));
endmodule
bind hsl_holdover_ctrl hsl_chk chk_u (.*);

/* hsl_holdover_ctrl.sv */
// Holdover, signal-loss and tuning control with AXI4-Lite registers
//
// Behaviour
// R01 - Signal loss after selected no-activity timeout
// R02 - Timeout detection only while enable set
// R03 - Type field sets status pin direction
// R04 - One buffer type bit per reference
// R05 - High trip compare, holdover and flag; the code enters holdover on a high trip only while rail detect is enabled
// R06 - Low trip compare, holdover and flag; the code enters holdover on a low trip only while rail detect is enabled
// R07 - Rail hit gives switch event if enabled
// R08 - Manual mode drives manual tuning code
// R09 - Mode bit picks automatic or manual
// R10 - Exit holdover after lock count clocks
// R11 - Force bit holds holdover regardless
// R12 - Forced holdover: manual or tracked code
// R13 - Force alone causes no switch event
// R14 - Crystal amplitude from two-bit code
// R15 - Software never writes readback register
// R16 - Readback shows DAC count at 23:14
// R17 - C4 capacitor code output
// R18 - C3 capacitor code output
// R19 - R4 resistor code output
// R20 - Lock-loss disable blocks holdover and switch
// R21 - Software avoids reserved field codes
`timescale 1ns/1ps
`include "hsl_cfg.svh"

module hsl_holdover_ctrl (
  input  wire logic         aclk,                // System clock
  input  wire logic         aresetn,             // Synchronous reset
  input  wire logic [7:0]   s_axi_awaddr,        // Write address
  input  wire logic         s_axi_awvalid,       // Write address valid
  output logic              s_axi_awready,       // Write address ready
  input  wire logic [31:0]  s_axi_wdata,         // Write data
  input  wire logic [3:0]   s_axi_wstrb,         // Write strobes
  input  wire logic         s_axi_wvalid,        // Write data valid
  output logic              s_axi_wready,        // Write data ready
  output logic [1:0]        s_axi_bresp,         // Write response
  output logic              s_axi_bvalid,        // Write response valid
  input  wire logic         s_axi_bready,        // Write response ready
  input  wire logic [7:0]   s_axi_araddr,        // Read address
  input  wire logic         s_axi_arvalid,       // Read address valid
  output logic              s_axi_arready,       // Read address ready
  output logic [31:0]       s_axi_rdata,         // Read data
  output logic [1:0]        s_axi_rresp,         // Read response
  output logic              s_axi_rvalid,        // Read data valid
  input  wire logic         s_axi_rready,        // Read data ready
  input  wire logic [2:0]   ref_clk_in,          // Reference inputs
  input  wire logic         first_loop_lock_flag, // Loop one lock
  input  wire logic         pd_clk_tick,         // Phase detector tick
  input  wire logic         first_loop_pump_output, // 1 tracked, 0 fixed
  input  wire logic [9:0]   tracked_tune_code,   // Tracked loop code
  input  wire logic         status_pin_in,       // Input1 status pin in
  output logic              status_pin_out,      // Input1 status pin out
  output logic              status_pin_oe,       // Input1 status pin oe
  output logic              status_pin_pull_up,  // Pull-up enable
  output logic              status_pin_pull_down, // Pull-down enable
  output logic [2:0]        ref_input_buffer_type, // 1 CMOS, 0 bipolar
  output logic [2:0]        signal_loss,         // Loss per reference
  output logic [9:0]        tune_dac_code,       // Tuning DAC code
  output logic              tune_high_flag,      // High trip reached
  output logic              tune_low_flag,       // Low trip reached
  output logic              holdover_active,     // In holdover
  output logic              clock_switch_event,  // Switch event pulse
  output logic [1:0]        crystal_amplitude_sel, // Crystal drive
  output logic [3:0]        second_loop_cap_c4,  // C4 select
  output logic [3:0]        second_loop_cap_c3,  // C3 select
  output logic [2:0]        second_loop_res_r4   // R4 select
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [7:0] los_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = 8'(`HSL_LOS_C0);
    case (sel)
      2'h1:    lim = 8'(`HSL_LOS_C1);
      2'h2:    lim = 8'(`HSL_LOS_C2);
      2'h3:    lim = 8'(`HSL_LOS_C3);
      default: lim = 8'(`HSL_LOS_C0);
    endcase
    return lim;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Volts scaled by 64*1023 so both ladders compare exactly
  function automatic logic [16:0] dac_scaled(input logic [9:0] k);
    return {1'b0, k, 6'h00};
  endfunction

  function automatic logic [16:0] trip_scaled(input logic [5:0] n);
    return 17'(`HSL_DAC_FULL * {11'h000, n});
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register storage

  logic [31:0]   ref_cfg;
  logic [31:0]   hold_cfg;
  logic [31:0]   xtal_cfg;
  logic [31:0]   filt_cfg;
  logic [31:0]   lock_cfg;

  logic          aw_full;
  logic          w_full;
  logic [5:0]    aw_idx;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;

  hsl_pkg::hsl_state_type state;
  hsl_pkg::hsl_code_type  hold_code;
  hsl_pkg::hsl_count_type lock_run;

  logic [2:0]    ref_prev;
  logic [7:0]    los_cnt [3];
  logic          lock_prev;
  logic          force_prev;
  logic          high_prev;
  logic          low_prev;

  ////////////////////////////////////////////////////////////////////
  // Field decode

  wire [1:0]  signal_loss_timeout_sel   = ref_cfg[`HSL_LOS_SEL];
  wire        signal_loss_detect_enable = ref_cfg[`HSL_LOS_EN];
  wire [2:0]  input1_status_pin_type    = ref_cfg[`HSL_PIN_TYPE];
  wire [5:0]  tune_high_trip_level      = ref_cfg[`HSL_HIGH_TRIP];
  wire [5:0]  tune_low_trip_level       = ref_cfg[`HSL_LOW_TRIP];
  wire        tune_rail_detect_enable   = ref_cfg[`HSL_RAIL_EN];
  wire [9:0]  manual_tune_code          = hold_cfg[`HSL_MAN_CODE];
  wire        manual_tune_mode          = hold_cfg[`HSL_MAN_MODE];
  wire [13:0] holdover_exit_lock_count  = hold_cfg[`HSL_EXIT_CNT];
  wire        force_holdover            = hold_cfg[`HSL_FORCE];
  wire        lock_loss_switch_disable  = lock_cfg[`HSL_LOCK_DIS];
  wire [7:0]  los_lim                   = los_limit(signal_loss_timeout_sel);

  ////////////////////////////////////////////////////////////////////
  // Tuning rails and holdover events

  // High trip sits (n+1)/64 below Vcc, low trip (n+1)/64 above ground
  wire [16:0] dac_v     = dac_scaled(tune_dac_code);
  wire [16:0] high_v    = trip_scaled(6'(`HSL_TRIP_TOP - {11'h000, tune_high_trip_level}));
  wire [16:0] low_v     = trip_scaled(6'(tune_low_trip_level + 6'h01));
  wire        at_high   = dac_v >= high_v;                      // R05
  wire        at_low    = dac_v <= low_v; // R06
  wire        rail_hit  = tune_rail_detect_enable &&
                          ((at_high && !high_prev) || (at_low && !low_prev)); // R07
  wire        lock_fall = lock_prev && !first_loop_lock_flag;
  wire        lock_loss = lock_fall && !lock_loss_switch_disable; // R20
  wire        force_on  = force_holdover && !force_prev;
  // Entering a forced holdover with lock low counts as lock loss
  wire        force_sw  = force_on && !first_loop_lock_flag &&
                          !lock_loss_switch_disable;            // R13
  wire        next_switch = rail_hit || lock_loss || force_sw;  // R07 R13 R20
  wire [13:0] exit_target = (holdover_exit_lock_count == 14'h0000) ? 14'h0001
                            : holdover_exit_lock_count;
  wire        lock_done = first_loop_lock_flag && pd_clk_tick &&
                          (lock_run + 14'h0001 >= exit_target); // R10
  wire        enter_hold = force_holdover || rail_hit || lock_loss; // R05 R06 R11

  hsl_pkg::hsl_state_type next_state;
  assign next_state =
    (state == hsl_pkg::HSL_TRACKING) ?
      (enter_hold ? hsl_pkg::HSL_HOLDOVER : hsl_pkg::HSL_TRACKING) :
      ((!force_holdover && lock_done && !rail_hit && !lock_loss) ?
        hsl_pkg::HSL_TRACKING : hsl_pkg::HSL_HOLDOVER);         // R10 R11

  // Forced or automatic holdover uses manual or frozen tracked code
  wire [9:0] hold_src   = first_loop_pump_output ? hold_code : manual_tune_code; // R12
  wire [9:0] run_src    = manual_tune_mode ? manual_tune_code : tracked_tune_code; // R08 R09
  wire [9:0] next_dac   = (state == hsl_pkg::HSL_HOLDOVER) ? hold_src : run_src;

  ////////////////////////////////////////////////////////////////////
  // Status pin

  wire pin_is_out = (input1_status_pin_type >= `HSL_PIN_OUT_PP) &&
                    (input1_status_pin_type <= `HSL_PIN_OUT_OD); // R03
  wire pin_val    = signal_loss[1];
  wire next_pin_out = (input1_status_pin_type == `HSL_PIN_OUT_INV) ? !pin_val :
                      (input1_status_pin_type == `HSL_PIN_OUT_OD) ? 1'b0 :
                      (input1_status_pin_type == `HSL_PIN_OUT_OS) ? 1'b1 : pin_val;
  wire next_pin_oe  = !pin_is_out ? 1'b0 :
                      (input1_status_pin_type == `HSL_PIN_OUT_OD) ? !pin_val :
                      (input1_status_pin_type == `HSL_PIN_OUT_OS) ? pin_val : 1'b1; // R03

  ////////////////////////////////////////////////////////////////////
  // Register read decode

  wire [5:0]  ar_idx = s_axi_araddr[7:2];
  wire [31:0] stat_word = {24'h000000, first_loop_lock_flag, status_pin_in,
                           tune_high_flag, tune_low_flag, signal_loss,
                           holdover_active};
  wire        rd_hit = (ar_idx == `HSL_IDX_REF) || (ar_idx == `HSL_IDX_HOLD) ||
                       (ar_idx == `HSL_IDX_XTAL) || (ar_idx == `HSL_IDX_RDBK) ||
                       (ar_idx == `HSL_IDX_FILT) || (ar_idx == `HSL_IDX_LOCKCTL) ||
                       (ar_idx == `HSL_IDX_STAT);
  wire [31:0] rdbk_word = {8'h00, tune_dac_code, 14'h0000}; // R16
  wire [31:0] rd_word =
    (ar_idx == `HSL_IDX_REF)     ? ref_cfg  :
    (ar_idx == `HSL_IDX_HOLD)    ? hold_cfg :
    (ar_idx == `HSL_IDX_XTAL)    ? xtal_cfg :
    (ar_idx == `HSL_IDX_RDBK)    ? rdbk_word :
    (ar_idx == `HSL_IDX_FILT)    ? filt_cfg :
    (ar_idx == `HSL_IDX_LOCKCTL) ? lock_cfg :
    (ar_idx == `HSL_IDX_STAT)    ? stat_word : `HSL_RESET_WORD;

  // Readback and status words are read only and take no writes
  wire wr_go  = aw_full && w_full && !s_axi_bvalid;
  wire wr_hit = (aw_idx == `HSL_IDX_REF) || (aw_idx == `HSL_IDX_HOLD) ||
                (aw_idx == `HSL_IDX_XTAL) || (aw_idx == `HSL_IDX_FILT) ||
                (aw_idx == `HSL_IDX_LOCKCTL);                   // R15
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b0;
      aw_idx        <= 6'h00;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_idx        <= s_axi_awaddr[7:2];
    end else begin
      s_axi_awready <= !aw_full && !s_axi_bvalid;
      aw_full       <= aw_full && !wr_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b0;
      w_data       <= `HSL_RESET_WORD;
      w_strb       <= 4'h0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else begin
      s_axi_wready <= !w_full && !s_axi_bvalid;
      w_full       <= w_full && !wr_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HSL_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `HSL_RESP_OKAY : `HSL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cfg  <= `HSL_RESET_WORD;
      hold_cfg <= `HSL_RESET_WORD;
      xtal_cfg <= `HSL_RESET_WORD;
      filt_cfg <= `HSL_RESET_WORD;
      lock_cfg <= `HSL_RESET_WORD;
    end else if (wr_go) begin
      if (aw_idx == `HSL_IDX_REF)
        ref_cfg <= merge(ref_cfg, w_data, w_strb, `HSL_MASK_REF);
      if (aw_idx == `HSL_IDX_HOLD)
        hold_cfg <= merge(hold_cfg, w_data, w_strb, `HSL_MASK_HOLD);
      if (aw_idx == `HSL_IDX_XTAL)
        xtal_cfg <= merge(xtal_cfg, w_data, w_strb, `HSL_MASK_XTAL);
      if (aw_idx == `HSL_IDX_FILT)
        filt_cfg <= merge(filt_cfg, w_data, w_strb, `HSL_MASK_FILT);
      if (aw_idx == `HSL_IDX_LOCKCTL)
        lock_cfg <= merge(lock_cfg, w_data, w_strb, `HSL_MASK_LOCKCTL);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `HSL_RESET_WORD;
      s_axi_rresp   <= `HSL_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `HSL_RESP_OKAY : `HSL_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Signal loss monitors

  // Any level change on a sampled reference counts as activity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev    <= 3'h0;
      signal_loss <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        los_cnt[i] <= 8'h00;
      end
    end else begin
      ref_prev <= ref_clk_in;
      for (int i = 0; i < 3; i++) begin
        if (!signal_loss_detect_enable || (ref_clk_in[i] != ref_prev[i])) begin
          los_cnt[i]     <= 8'h00; // R02
          signal_loss[i] <= 1'b0; // R02
        end else if (los_cnt[i] + 8'h01 >= los_lim) begin
          los_cnt[i]     <= los_lim;
          signal_loss[i] <= 1'b1; // R01
        end else begin
          los_cnt[i]     <= los_cnt[i] + 8'h01; // R01
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Holdover control

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= hsl_pkg::HSL_TRACKING;
      hold_code  <= 10'h000;
      lock_run   <= 14'h0000;
      lock_prev  <= 1'b0;
      force_prev <= 1'b0;
      high_prev  <= 1'b0;
      low_prev   <= 1'b0;
    end else begin
      state      <= next_state;
      lock_prev  <= first_loop_lock_flag;
      force_prev <= force_holdover;
      high_prev  <= at_high;
      low_prev   <= at_low;
      if (state == hsl_pkg::HSL_TRACKING)
        hold_code <= tune_dac_code; // R12
      if (!first_loop_lock_flag || state == hsl_pkg::HSL_TRACKING)
        lock_run <= 14'h0000; // R10
      else if (pd_clk_tick && lock_run != 14'h3fff)
        lock_run <= lock_run + 14'h0001; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune_dac_code         <= 10'h000;
      tune_high_flag        <= 1'b0;
      tune_low_flag         <= 1'b0;
      holdover_active       <= 1'b0;
      clock_switch_event    <= 1'b0;
      status_pin_out        <= 1'b0;
      status_pin_oe         <= 1'b0;
      status_pin_pull_up    <= 1'b0;
      status_pin_pull_down  <= 1'b0;
      ref_input_buffer_type <= 3'h0;
      crystal_amplitude_sel <= 2'h0;
      second_loop_cap_c4    <= 4'h0;
      second_loop_cap_c3    <= 4'h0;
      second_loop_res_r4    <= 3'h0;
    end else begin
      tune_dac_code         <= next_dac; // R08 R12
      tune_high_flag        <= at_high; // R05
      tune_low_flag         <= at_low; // R06
      holdover_active       <= next_state == hsl_pkg::HSL_HOLDOVER;
      clock_switch_event    <= next_switch; // R07 R13
      status_pin_out        <= next_pin_out; // R03
      status_pin_oe         <= next_pin_oe; // R03
      status_pin_pull_up    <= input1_status_pin_type == `HSL_PIN_IN_PU;
      status_pin_pull_down  <= input1_status_pin_type == `HSL_PIN_IN_PD;
      ref_input_buffer_type <= ref_cfg[`HSL_BUF_TYPE]; // R04
      crystal_amplitude_sel <= xtal_cfg[`HSL_CRYSTAL_AMPLITUDE_SEL]; // R14
      second_loop_cap_c4    <= filt_cfg[`HSL_CAP_C4]; // R17
      second_loop_cap_c3    <= filt_cfg[`HSL_CAP_C3]; // R18
      second_loop_res_r4    <= filt_cfg[`HSL_RES_R4]; // R19
    end
  end

endmodule

/* hsl_pkg.sv */
// Types shared by the holdover and signal-loss control block
package hsl_pkg;
  typedef enum logic [0:0] {
    HSL_TRACKING = 1'b0,
    HSL_HOLDOVER = 1'b1
  } hsl_state_type;
  typedef logic [9:0]  hsl_code_type;
  typedef logic [13:0] hsl_count_type;
endpackage

/* hsl_ref_model.sv */
// Reference inputs and detector tick source
`timescale 1ns/1ps
module hsl_ref_model (
  input  wire logic [2:0] run,         // Toggle enable per input
  input  wire logic       aclk,        // System clock
  output logic      [2:0] ref_clk_out, // Reference clocks
  output logic            pd_tick      // Detector tick
);
  logic [2:0] div = 3'h0;
  initial ref_clk_out = 3'h0;
  always @(posedge aclk) begin
    div <= div + 3'h1;
    ref_clk_out <= ref_clk_out ^ run;
  end
  assign pd_tick = (div == 3'h7);
endmodule

/* tb_top.sv */
// Self-checking bench for the holdover control block
`timescale 1ns/1ps
`include "hsl_cfg.svh"
`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, first_loop_lock_flag = 1'b1, last_pin = 1'b0;
  logic        first_loop_pump_output = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, pd_clk_tick, status_pin_in, status_pin_out, status_pin_oe, status_pin_pull_up;
  logic        status_pin_pull_down, tune_high_flag, tune_low_flag, holdover_active, clock_switch_event;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, second_loop_cap_c4, second_loop_cap_c3;
  logic [2:0]  run = 3'h7, ref_clk_in, ref_input_buffer_type, signal_loss, second_loop_res_r4;
  logic [1:0]  s_axi_bresp, s_axi_rresp, crystal_amplitude_sel;
  logic [9:0]  tracked_tune_code = 10'h155, tune_dac_code;
  int          mismatches = 0, total_checks = 0, events = 0, e;
  always #5 aclk = ~aclk;
  hsl_holdover_ctrl dut_u (.*);
  hsl_ref_model ref_u (.run(run), .aclk(aclk), .ref_clk_out(ref_clk_in), .pd_tick(pd_clk_tick));
  // Released pin with no pull enabled shows a moving level
  assign status_pin_in = status_pin_oe ? status_pin_out : status_pin_pull_up ? 1'b1 : status_pin_pull_down ? 1'b0 : ~last_pin;
  always @(posedge aclk) last_pin <= status_pin_in;
  always @(posedge aclk) if (clock_switch_event === 1'b1) events <= events + 1;
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    `CHK("bresp", s_axi_bresp, r)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    `CHK("rresp", s_axi_rresp, r)
    `CHK("rdata", s_axi_rdata, d)
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_regs();
    wr(8'h38, 32'hd67fcfc0, `HSL_RESP_OKAY);
    rd(8'h38, 32'hd67fcfc0, `HSL_RESP_OKAY);
    `CHK("buf_type", ref_input_buffer_type, 3'h7)
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, {i[1:0], 30'h0}, `HSL_RESP_OKAY);
      `CHK("xtal", crystal_amplitude_sel, i[1:0])
    end
    wr(8'h60, 32'hd7400000, `HSL_RESP_OKAY);
    `CHK("cap_c4", second_loop_cap_c4, 4'hd)
    `CHK("cap_c3", second_loop_cap_c3, 4'h7)
    `CHK("res_r4", second_loop_res_r4, 3'h4)
    wr(8'h5c, 32'hffffffff, `HSL_RESP_SLVERR);
    rd(8'h00, 32'h0, `HSL_RESP_SLVERR);
  endtask
  task automatic test_dac();
    wr(8'h3c, 32'h801000c0, `HSL_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("manual_dac", tune_dac_code, 10'h200)
    rd(8'h5c, 32'h00800000, `HSL_RESP_OKAY);
    wr(8'h3c, 32'h800000c0, `HSL_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("auto_dac", tune_dac_code, 10'h155)
  endtask
  task automatic test_los();
    run <= 3'h6;
    repeat (10) @(posedge aclk);
    `CHK("loss_short", signal_loss, 3'h1)
    `CHK("pin_oe_drive", status_pin_oe, 1'b1)
    `CHK("pin_out", status_pin_out, 1'b0)
    run <= 3'h7;
    wr(8'h38, 32'h167fcfc0, `HSL_RESP_OKAY);
    `CHK("loss_cleared", signal_loss, 3'h0)
    run <= 3'h5;
    repeat (100) @(posedge aclk);
    `CHK("loss_early", signal_loss, 3'h0)
    repeat (30) @(posedge aclk);
    `CHK("loss_long", signal_loss, 3'h2)
    `CHK("pin_oe_release", status_pin_oe, 1'b0)
    wr(8'h38, 32'h067fcfc0, `HSL_RESP_OKAY);
    `CHK("loss_disabled", signal_loss, 3'h0)
    run <= 3'h7;
  endtask
  task automatic test_force();
    wr(8'h34, 32'h0, `HSL_RESP_OKAY);
    e = events;
    wr(8'h3c, 32'h800000e0, `HSL_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("forced", holdover_active, 1'b1)
    `CHK("forced_dac", tune_dac_code, 10'h200)
    `CHK("force_events", events, e)
    first_loop_lock_flag <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("lockfall_events", events, e + 1)
    wr(8'h3c, 32'h800000c0, `HSL_RESP_OKAY);
    repeat (200) @(posedge aclk);
    `CHK("stay_unlocked", holdover_active, 1'b1)
    first_loop_lock_flag <= 1'b1;
    repeat (60) @(posedge aclk);
    `CHK("exit_locked", holdover_active, 1'b0)
    wr(8'h34, 32'h00008000, `HSL_RESP_OKAY);
    first_loop_lock_flag <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHK("masked_hold", holdover_active, 1'b0)
    `CHK("masked_events", events, e + 1)
    first_loop_lock_flag <= 1'b1;
  endtask
  task automatic test_rail();
    wr(8'h3c, 32'h401000c0, `HSL_RESP_OKAY);
    wr(8'h38, 32'hd6700020, `HSL_RESP_OKAY);
    e = events;
    wr(8'h3c, 32'hffd000c0, `HSL_RESP_OKAY);
    repeat (6) @(posedge aclk);
    `CHK("high_flag", tune_high_flag, 1'b1)
    `CHK("rail_hold", holdover_active, 1'b1)
    `CHK("rail_events", events, e + 1)
    wr(8'h38, 32'hd6700000, `HSL_RESP_OKAY);
    wr(8'h3c, 32'h001000c0, `HSL_RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("low_flag", tune_low_flag, 1'b1)
    `CHK("no_rail_events", events, e + 1)
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_dac();
    test_los();
    test_force();
    test_rail();
    test_done();
  end
endmodule
